/* File: shared/dstg_regs.vh */
`ifndef DSTG_REGS_VH
`define DSTG_REGS_VH

// Register byte offsets on the Avalon-MM slave
`define DSTG_OFS_CTRL      5'h00
`define DSTG_OFS_PITCH_A   5'h04
`define DSTG_OFS_PITCH_B   5'h08
`define DSTG_OFS_BURST     5'h0C
`define DSTG_OFS_STATUS    5'h10

// Control register fields
`define DSTG_CTRL_RUN      0
`define DSTG_CTRL_KEYPAD   1
`define DSTG_CTRL_SEL_LO   2
`define DSTG_CTRL_SEL_HI   3
`define DSTG_CTRL_CODE_LO  4
`define DSTG_CTRL_CODE_HI  7
`define DSTG_CTRL_CNT_LO   8
`define DSTG_CTRL_CNT_HI   11
`define DSTG_CTRL_RESET    32'h0000_0000

// Source select encodings
`define DSTG_SEL_A         2'h0
`define DSTG_SEL_B         2'h1
`define DSTG_SEL_MIX       2'h2
`define DSTG_SEL_RAMP      2'h3

// Burst time fields and range
`define DSTG_ON_LO         0
`define DSTG_ON_HI         7
`define DSTG_OFF_LO        8
`define DSTG_OFF_HI        15
`define DSTG_BURST_RESET   32'h0000_0000
`define DSTG_UNITS_MAX     8'hC8

// Beep timing: 10 ms steps, 40 MHz clock
`define DSTG_BEEP_STEP_MS  10
`define DSTG_CLK_MHZ       40
`define DSTG_STEP_CYCLES   (`DSTG_BEEP_STEP_MS * 1000 * `DSTG_CLK_MHZ)

// Keypad pitch words, 12000 divisor family
`define DSTG_K12_R697      16'h0EDF
`define DSTG_K12_R770      16'h106D
`define DSTG_K12_R852      16'h122D
`define DSTG_K12_R941      16'h1413
`define DSTG_K12_C1209     16'h19CB
`define DSTG_K12_C1336     16'h1C80
`define DSTG_K12_C1477     16'h1F82
`define DSTG_K12_C1633     16'h22D6

// Keypad pitch words, 11025 divisor family
`define DSTG_K11_R697      16'h102F
`define DSTG_K11_R770      16'h11E1
`define DSTG_K11_R852      16'h13C9
`define DSTG_K11_R941      16'h15DA
`define DSTG_K11_C1209     16'h1C13
`define DSTG_K11_C1336     16'h1F06
`define DSTG_K11_C1477     16'h224C
`define DSTG_K11_C1633     16'h25EB

`endif

/* File: verilog/dstg_sine_src.v */
`timescale 1ns/1ps
`default_nettype none

module dstg_sine_src (
   // Clock and reset
   input  wire        ref_clk,
   input  wire        rst,
   // Control
   input  wire        enable,
   input  wire        sample_tick,
   input  wire        ramp_mode,
   input  wire [15:0] pitch,
   // Amplitude
   output reg  [15:0] amp_r
);

   reg  [15:0] phase_r;
   wire [15:0] table_phase;
   wire [14:0] x;
   wire [15:0] x_c;
   wire [30:0] prod;
   wire [15:0] mag;

   // Ramp mode walks half a sine from trough to crest per period
   assign table_phase = ramp_mode ?
                        ({1'b0, phase_r[15:1]} + 16'hC000) : phase_r;
   assign x    = table_phase[14:0];
   assign x_c  = 16'h8000 - {1'b0, x};
   // Parabolic half-wave; cheaper than a table, within a few percent
   assign prod = {16'h0000, x} * {15'h0000, x_c};
   assign mag  = (prod[30:13] > 18'h0_7FFF) ? 16'h7FFF : prod[28:13];

   // Phase accumulates once per sample and wraps modulo 2^16
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         phase_r <= 16'h0000;
         amp_r   <= 16'h0000;
      end else if (!enable) begin
         phase_r <= 16'h0000; // Restart at zero phase for a clean onset
         amp_r   <= 16'h0000;
      end else if (sample_tick) begin
         phase_r <= phase_r + pitch;
         amp_r   <= table_phase[15] ? (16'h0000 - mag) : mag;
      end
   end

endmodule // dstg_sine_src

`default_nettype wire

/* File: verilog/dstg_period_timer.v */
`timescale 1ns/1ps
`default_nettype none

module dstg_period_timer #(
   parameter UNIT_CYCLES = 400000
) (
   // Clock and reset
   input  wire       ref_clk,
   input  wire       rst,
   // Control
   input  wire       load,
   input  wire [7:0] units,
   // Expiry
   output reg        done_r
);

   localparam integer UNIT_LAST_I = UNIT_CYCLES - 1;
   localparam [18:0]  UNIT_LAST   = UNIT_LAST_I[18:0];

   reg [18:0] pre_r;
   reg [7:0]  left_r;
   reg        busy_r;

   // Prescaler makes 10 ms steps, step counter counts the period
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pre_r  <= 19'h0_0000;
         left_r <= 8'h00;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (load) begin
            pre_r  <= 19'h0_0000;
            left_r <= units;
            busy_r <= 1'b1;
         end else if (busy_r) begin
            if (pre_r == UNIT_LAST) begin
               pre_r <= 19'h0_0000;
               if (left_r <= 8'h01) begin
                  busy_r <= 1'b0;
                  done_r <= 1'b1;
               end else begin
                  left_r <= left_r - 8'h01;
               end
            end else begin
               pre_r <= pre_r + 19'h0_0001;
            end
         end
      end
   end

endmodule // dstg_period_timer

`default_nettype wire

/* File: verilog/dstg_top.v */
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "dstg_regs.vh"
`default_nettype none

// Overview of operation
// - Two independent sine sources, each tuned by its own 16-bit pitch word.
// - Pitch word is 2^16*f/12000 for the 8 to 96 kHz rate family.
// - Pitch word is 2^16*f/11025 for the 11.025 kHz rate family.
// - Each pitch word is two byte fields, upper bits 15:8, lower 7:0.
// - Output comes from source A, source B or their combination.
// - Source select value 3 produces an S-shaped ramp instead of sine.
// - Keypad enable drives both sources with the keypad tone pair.
// - Row tone on source B, column tone on source A, per keypad code.
// - Burst count gives 1,2,3,4,8,16,32 beeps or continuous on 110/111.
// - Beep on period programmable from 10 ms to 2 s.
// - Beep off period programmable from 10 ms to 2 s.
// - Setting run starts tone generation; clearing it requests a halt.
// - Halt waits for end of beep cycle, or zero crossing if continuous.
// - Run bit clears itself when the programmed beeps are done.
// - Scaling and limit follow the output-path sample rate; here only the keypad pitch words follow rate_family_11k.
module dstg_top #(
   parameter STEP_CYCLES = `DSTG_STEP_CYCLES
) (
   // Clock and reset
   input  wire        ref_clk,
   input  wire        rst,
   // Avalon-MM slave
   input  wire [4:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output wire        avs_waitrequest,
   // Output sample timing
   input  wire        sample_tick,
   input  wire        rate_family_11k,
   // Tone output to the mixer
   output reg  [15:0] tone_sample,
   output reg         tone_valid,
   output wire        tone_active
);

   // Sequencer states
   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_ON   = 2'b01;
   localparam [1:0] ST_OFF  = 2'b10;

   // Bus handshake
   reg         ack_r;
   wire        wr_en;
   wire        rd_take;
   reg  [31:0] rd_mux;

   // Software fields
   reg         run_r;
   reg         run_nxt;
   reg         keypad_en_r;
   reg  [1:0]  src_sel_r;
   reg  [3:0]  key_code_r;
   reg  [3:0]  burst_cnt_r;
   reg  [15:0] pitch_a_r;
   reg  [15:0] pitch_b_r;
   reg  [7:0]  on_time_r;
   reg  [7:0]  off_time_r;

   // Sequencer
   reg  [1:0]  state_r;
   reg  [1:0]  state_nxt;
   reg  [5:0]  beeps_r;
   reg  [5:0]  beeps_nxt;
   reg  [5:0]  target;
   reg         hw_clear;
   reg         tmr_load;
   reg  [7:0]  tmr_units;
   wire        tmr_done;
   wire        continuous;
   wire [7:0]  on_units;
   wire [7:0]  off_units;

   // Sources and mix
   reg  [1:0]  key_row;
   reg  [1:0]  key_col;
   reg  [15:0] row_word;
   reg  [15:0] col_word;
   wire [31:0] src_pitch;
   wire [31:0] src_amp;
   wire        running;
   wire        ramp_on;
   reg         tick_d_r;
   reg  [15:0] mix;
   wire [16:0] sum_ab;
   reg         prev_sign_r;
   wire        zero_cross;

   // Answer one cycle after a request; read data are registered
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
   assign wr_en   = avs_write & ack_r;
   assign rd_take = avs_read & ~ack_r;

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (avs_read | avs_write) & ~ack_r;
      end
   end

   // Read multiplexer; unmapped offsets read as zero
   always @* begin
      rd_mux = 32'h0000_0000;
      case (avs_address)
         `DSTG_OFS_CTRL: begin
            rd_mux[`DSTG_CTRL_RUN]    = run_r;
            rd_mux[`DSTG_CTRL_KEYPAD] = keypad_en_r;
            rd_mux[`DSTG_CTRL_SEL_HI:`DSTG_CTRL_SEL_LO]   = src_sel_r;
            rd_mux[`DSTG_CTRL_CODE_HI:`DSTG_CTRL_CODE_LO] = key_code_r;
            rd_mux[`DSTG_CTRL_CNT_HI:`DSTG_CTRL_CNT_LO]   = burst_cnt_r;
         end
         `DSTG_OFS_PITCH_A: rd_mux[15:0] = pitch_a_r;
         `DSTG_OFS_PITCH_B: rd_mux[15:0] = pitch_b_r;
         `DSTG_OFS_BURST: begin
            rd_mux[`DSTG_ON_HI:`DSTG_ON_LO]   = on_time_r;
            rd_mux[`DSTG_OFF_HI:`DSTG_OFF_LO] = off_time_r;
         end
         `DSTG_OFS_STATUS: begin
            rd_mux[1:0]  = state_r;
            rd_mux[13:8] = beeps_r;
         end
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (rd_take) begin
         avs_readdata <= rd_mux;
      end
   end

   // Run bit: a software write beats a same-cycle self clear
   always @* begin
      run_nxt = run_r;
      if (hw_clear) begin
         run_nxt = 1'b0;
      end
      if (wr_en && avs_address == `DSTG_OFS_CTRL && avs_byteenable[0]) begin
         run_nxt = avs_writedata[`DSTG_CTRL_RUN];
      end
   end

   // Software writable fields, byte lanes honoured
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         run_r       <= 1'b0;
         keypad_en_r <= 1'b0;
         src_sel_r   <= `DSTG_SEL_A;
         key_code_r  <= 4'h0;
         burst_cnt_r <= 4'h0;
         pitch_a_r   <= 16'h0000;
         pitch_b_r   <= 16'h0000;
         on_time_r   <= 8'h00;
         off_time_r  <= 8'h00;
      end else begin
         run_r <= run_nxt;
         if (wr_en) begin
            case (avs_address)
               `DSTG_OFS_CTRL: begin
                  if (avs_byteenable[0]) begin
                     keypad_en_r <= avs_writedata[`DSTG_CTRL_KEYPAD];
                     src_sel_r   <=
                        avs_writedata[`DSTG_CTRL_SEL_HI:`DSTG_CTRL_SEL_LO];
                     key_code_r  <=
                        avs_writedata[`DSTG_CTRL_CODE_HI:`DSTG_CTRL_CODE_LO];
                  end
                  if (avs_byteenable[1]) begin
                     burst_cnt_r <=
                        avs_writedata[`DSTG_CTRL_CNT_HI:`DSTG_CTRL_CNT_LO];
                  end
               end
               `DSTG_OFS_PITCH_A: begin
                  if (avs_byteenable[0]) begin
                     pitch_a_r[7:0] <= avs_writedata[7:0];
                  end
                  if (avs_byteenable[1]) begin
                     pitch_a_r[15:8] <= avs_writedata[15:8];
                  end
               end
               `DSTG_OFS_PITCH_B: begin
                  if (avs_byteenable[0]) begin
                     pitch_b_r[7:0] <= avs_writedata[7:0];
                  end
                  if (avs_byteenable[1]) begin
                     pitch_b_r[15:8] <= avs_writedata[15:8];
                  end
               end
               `DSTG_OFS_BURST: begin
                  if (avs_byteenable[0]) begin
                     on_time_r <= avs_writedata[`DSTG_ON_HI:`DSTG_ON_LO];
                  end
                  if (avs_byteenable[1]) begin
                     off_time_r <= avs_writedata[`DSTG_OFF_HI:`DSTG_OFF_LO];
                  end
               end
               default: begin
                  run_r <= run_nxt; // Unmapped writes are dropped
               end
            endcase
         end
      end
   end

   // Burst count decode; bit 3 set with a count code means 32
   assign continuous = (burst_cnt_r[2:1] == 2'b11);
   always @* begin
      case (burst_cnt_r[2:0])
         3'b000:  target = 6'd1;
         3'b001:  target = 6'd2;
         3'b010:  target = 6'd3;
         3'b011:  target = 6'd4;
         3'b100:  target = 6'd8;
         3'b101:  target = 6'd16;
         default: target = 6'd0;
      endcase
      if (burst_cnt_r[3] && !continuous) begin
         target = 6'd32;
      end
   end

   // Field value n gives (n+1) steps of 10 ms, clamped to 2 s
   assign on_units  = (on_time_r >= `DSTG_UNITS_MAX - 8'h01) ?
                      `DSTG_UNITS_MAX : on_time_r + 8'h01;
   assign off_units = (off_time_r >= `DSTG_UNITS_MAX - 8'h01) ?
                      `DSTG_UNITS_MAX : off_time_r + 8'h01;

   // Beep sequencer: on period, then off period, repeat
   always @* begin
      state_nxt = state_r;
      beeps_nxt = beeps_r;
      hw_clear  = 1'b0;
      tmr_load  = 1'b0;
      tmr_units = on_units;
      case (state_r)
         ST_IDLE: begin
            if (run_r) begin
               state_nxt = ST_ON;
               beeps_nxt = 6'd0;
               tmr_load  = 1'b1;
            end
         end
         ST_ON: begin
            if (continuous && !run_r && zero_cross) begin
               state_nxt = ST_IDLE;
            end else if (tmr_done) begin
               state_nxt = ST_OFF;
               tmr_load  = 1'b1;
               tmr_units = off_units;
            end
         end
         ST_OFF: begin
            if (continuous && !run_r) begin
               state_nxt = ST_IDLE;
            end else if (tmr_done) begin
               beeps_nxt = beeps_r + 6'd1;
               if (!continuous && (beeps_r + 6'd1 == target)) begin
                  state_nxt = ST_IDLE;
                  hw_clear  = 1'b1;
               end else if (!run_r) begin
                  state_nxt = ST_IDLE;
               end else begin
                  state_nxt = ST_ON;
                  tmr_load  = 1'b1;
               end
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_r <= ST_IDLE;
         beeps_r <= 6'd0;
      end else begin
         state_r <= state_nxt;
         beeps_r <= beeps_nxt;
      end
   end

   dstg_period_timer #(
      .UNIT_CYCLES (STEP_CYCLES)
   ) u_timer (
      .ref_clk (ref_clk),
      .rst     (rst),
      .load    (tmr_load),
      .units   (tmr_units),
      .done_r  (tmr_done)
   );

   // Keypad code to row and column
   always @* begin
      case (key_code_r)
         4'h1: begin key_row = 2'd0; key_col = 2'd0; end
         4'h2: begin key_row = 2'd0; key_col = 2'd1; end
         4'h3: begin key_row = 2'd0; key_col = 2'd2; end
         4'hA: begin key_row = 2'd0; key_col = 2'd3; end
         4'h4: begin key_row = 2'd1; key_col = 2'd0; end
         4'h5: begin key_row = 2'd1; key_col = 2'd1; end
         4'h6: begin key_row = 2'd1; key_col = 2'd2; end
         4'hB: begin key_row = 2'd1; key_col = 2'd3; end
         4'h7: begin key_row = 2'd2; key_col = 2'd0; end
         4'h8: begin key_row = 2'd2; key_col = 2'd1; end
         4'h9: begin key_row = 2'd2; key_col = 2'd2; end
         4'hC: begin key_row = 2'd2; key_col = 2'd3; end
         4'hE: begin key_row = 2'd3; key_col = 2'd0; end
         4'h0: begin key_row = 2'd3; key_col = 2'd1; end
         4'hF: begin key_row = 2'd3; key_col = 2'd2; end
         default: begin key_row = 2'd3; key_col = 2'd3; end
      endcase
   end

   // Keypad pitch words scaled for the output-path rate family
   always @* begin
      case ({rate_family_11k, key_row})
         3'b000:  row_word = `DSTG_K12_R697;
         3'b001:  row_word = `DSTG_K12_R770;
         3'b010:  row_word = `DSTG_K12_R852;
         3'b011:  row_word = `DSTG_K12_R941;
         3'b100:  row_word = `DSTG_K11_R697;
         3'b101:  row_word = `DSTG_K11_R770;
         3'b110:  row_word = `DSTG_K11_R852;
         default: row_word = `DSTG_K11_R941;
      endcase
      case ({rate_family_11k, key_col})
         3'b000:  col_word = `DSTG_K12_C1209;
         3'b001:  col_word = `DSTG_K12_C1336;
         3'b010:  col_word = `DSTG_K12_C1477;
         3'b011:  col_word = `DSTG_K12_C1633;
         3'b100:  col_word = `DSTG_K11_C1209;
         3'b101:  col_word = `DSTG_K11_C1336;
         3'b110:  col_word = `DSTG_K11_C1477;
         default: col_word = `DSTG_K11_C1633;
      endcase
   end

   // Keypad overrides software pitch: column on A, row on B
   assign src_pitch[15:0]  = keypad_en_r ? col_word : pitch_a_r;
   assign src_pitch[31:16] = keypad_en_r ? row_word : pitch_b_r;
   assign running = (state_r != ST_IDLE);
   assign ramp_on = (src_sel_r == `DSTG_SEL_RAMP) && !keypad_en_r;

   // Two independent sources; phases run through the off period too
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_src
         dstg_sine_src u_src (
            .ref_clk     (ref_clk),
            .rst         (rst),
            .enable      (running),
            .sample_tick (sample_tick),
            .ramp_mode   (ramp_on && (g == 0)),
            .pitch       (src_pitch[16*g+15:16*g]),
            .amp_r       (src_amp[16*g+15:16*g])
         );
      end
   endgenerate

   // Source selection; keypad always sums both tones
   assign sum_ab = {src_amp[15], src_amp[15:0]} +
                   {src_amp[31], src_amp[31:16]};
   always @* begin
      if (keypad_en_r) begin
         mix = sum_ab[16:1];
      end else begin
         case (src_sel_r)
            `DSTG_SEL_A:   mix = src_amp[15:0];
            `DSTG_SEL_B:   mix = src_amp[31:16];
            `DSTG_SEL_MIX: mix = sum_ab[16:1];
            default:       mix = src_amp[15:0];
         endcase
      end
   end

   // Sign change or exact zero on a fresh sample counts as crossing
   assign zero_cross = tick_d_r &&
                       ((mix == 16'h0000) || (mix[15] != prev_sign_r));

   // Output sample one cycle after the sources update
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tick_d_r    <= 1'b0;
         prev_sign_r <= 1'b0;
         tone_sample <= 16'h0000;
         tone_valid  <= 1'b0;
      end else begin
         tick_d_r   <= sample_tick;
         tone_valid <= tick_d_r;
         if (tick_d_r) begin
            prev_sign_r <= mix[15];
            // Next state gates it, so a halt at a crossing leaves zero held
            tone_sample <= (state_nxt == ST_ON) ? mix : 16'h0000;
         end
      end
   end

   assign tone_active = running;

endmodule // dstg_top

`default_nettype wire

/* File: bench/dstg_checker.sv */
`timescale 1ns/1ps
`default_nettype none

module dstg_checker (
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        rst,
   // Avalon-MM slave
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // Tone side
   input wire logic        sample_tick,
   input wire logic [15:0] tone_sample,
   input wire logic        tone_valid,
   input wire logic        tone_active
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Any request in flight
   wire req = avs_read | avs_write;

   chk_wait_first: assert property (
      req && !$past(req) |-> avs_waitrequest)
      else $error("first request cycle not stalled");
   chk_wait_one: assert property (
      req && avs_waitrequest |=> !avs_waitrequest)
      else $error("stall longer than one cycle");
   chk_read_hold: assert property (
      !avs_read |=> $stable(avs_readdata))
      else $error("read data moved without a read");
   chk_valid_lat: assert property (
      sample_tick && tone_active |-> ##2 (tone_valid || !tone_active))
      else $error("no sample two cycles after tick");
   chk_valid_src: assert property (
      tone_valid |-> $past(sample_tick, 2))
      else $error("sample without a tick");
   chk_valid_pulse: assert property (
      tone_valid |=> !tone_valid)
      else $error("sample strobe longer than one cycle");
   chk_idle_quiet: assert property (
      (!tone_active) [*3] |-> tone_sample == 16'h0000)
      else $error("output not silent while idle");
   chk_start_write: assert property (
      $rose(tone_active) |->
         $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
      else $error("tone started without a write");

   // Main scenarios
   cover property ($rose(tone_active));
   cover property ($fell(tone_active));
   cover property (avs_read && !avs_waitrequest);
endmodule // dstg_checker

bind dstg_top dstg_checker dstg_checker_inst (
   .ref_clk(ref_clk), .rst(rst), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .sample_tick(sample_tick),
   .tone_sample(tone_sample), .tone_valid(tone_valid),
   .tone_active(tone_active));

`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`include "dstg_regs.vh"
`default_nettype none

module tb_top;
   // Design ports
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic [4:0]  avs_address = 5'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0]  avs_byteenable = 4'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        sample_tick = 1'b0;
   logic        rate_family_11k = 1'b0;
   logic [15:0] tone_sample;
   logic        tone_valid;
   logic        tone_active;
   // Bench state
   int          mismatches = 0;
   int          check_count = 0;
   logic [1:0]  tk = 2'h0;
   logic [31:0] q;
   logic signed [15:0] cap [12];

   // Short time unit keeps beep periods to a few cycles
   dstg_top #(.STEP_CYCLES(8)) dstg_top_inst (
      .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .sample_tick(sample_tick), .rate_family_11k(rate_family_11k),
      .tone_sample(tone_sample), .tone_valid(tone_valid),
      .tone_active(tone_active));

   // Clock, 25 ns period
   always #12.5 ref_clk = ~ref_clk;

   // Tick every fourth cycle, above the minimum spacing
   always @(posedge ref_clk) begin
      tk <= tk + 2'h1;
      sample_tick <= (tk == 2'h3);
   end

   task automatic check(input logic [31:0] seen, exp, input string w);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s exp %h seen %h", w, exp, seen);
      end
   endtask

   // One transfer, held until the stall is seen low
   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [31:0] d, input logic [3:0] be);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= ~wr;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask

   task automatic rd(input logic [4:0] a);
      bus(1'b0, a, 32'h0000_0000, 4'hF);
   endtask

   // Continuous run, grab n samples, then halt and bound the stop
   task automatic play(input logic [11:0] c, input int n);
      int k;
      while (tk != 2'h3) @(posedge ref_clk); // First capture is zero phase
      wr(`DSTG_OFS_CTRL, {20'h0_0000, c | 12'h001});
      for (int i = 0; i < n; i++) begin
         do @(posedge ref_clk); while (tone_valid !== 1'b1);
         cap[i] = tone_sample;
      end
      wr(`DSTG_OFS_CTRL, {20'h0_0000, c & 12'hFFE});
      k = 0;
      while (tone_active !== 1'b0 && k < 200) begin
         @(posedge ref_clk);
         k++;
      end
      check(k < 200, 1'b1, "halt at zero crossing");
   endtask

   task automatic t_reset;
      rd(`DSTG_OFS_CTRL);
      check(q, `DSTG_CTRL_RESET, "ctrl reset");
      rd(`DSTG_OFS_BURST);
      check(q, `DSTG_BURST_RESET, "burst reset");
      rd(`DSTG_OFS_STATUS);
      check(q, 32'h0000_0000, "status reset");
      wr(5'h14, 32'hFFFF_FFFF);
      rd(5'h14);
      check(q, 32'h0000_0000, "unmapped");
   endtask

   // Byte lanes of each pitch word land alone
   task automatic t_pitch;
      logic [31:0] d;
      logic [4:0]  a;
      for (int i = 0; i < 2; i++) begin
         a = i ? `DSTG_OFS_PITCH_B : `DSTG_OFS_PITCH_A;
         d = i ? 32'hDEAD_5A3C : 32'hBEEF_C3A5;
         wr(a, d);
         bus(1'b1, a, ~d, 4'h2);
         bus(1'b1, a, ~d, 4'hC);
         rd(a);
         check(q, {16'h0000, ~d[15:8], d[7:0]}, "pitch lanes");
      end
   endtask

   task automatic t_burst;
      logic [3:0] code [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8};
      int beeps [7] = '{1, 2, 3, 4, 8, 16, 32};
      wr(`DSTG_OFS_BURST, 32'h0000_0000);
      for (int i = 0; i < 7; i++) begin
         wr(`DSTG_OFS_CTRL, {20'h0_0000, code[i], 8'h01});
         do rd(`DSTG_OFS_CTRL); while (q[0] !== 1'b0);
         rd(`DSTG_OFS_STATUS);
         check(q[13:8], beeps[i], "beeps done");
         check(q[1:0], 2'h0, "idle after burst");
      end
   endtask

   // Halt in the first on period of two beeps: one beep only
   task automatic t_period;
      int n;
      logic on;
      on = 1'b0;
      wr(`DSTG_OFS_PITCH_A, 32'h0000_1000);
      wr(`DSTG_OFS_BURST, 32'h0000_0302);
      wr(`DSTG_OFS_CTRL, 32'h0000_0101);
      wr(`DSTG_OFS_CTRL, 32'h0000_0100);
      n = 0;
      while (tone_active !== 1'b0 && n < 200) begin
         @(posedge ref_clk);
         n++;
         if (tone_valid === 1'b1 && n < 18 && tone_sample !== 16'h0000) on = 1;
         if (tone_valid === 1'b1 && n > 26)
            check(tone_sample, 16'h0000, "off period");
      end
      check(on, 1'b1, "tone in on period");
      check(n >= 50 && n <= 60, 1'b1, "one beep length");
   endtask

   task automatic t_wave;
      logic signed [15:0] a [12];
      logic signed [15:0] b [12];
      logic signed [16:0] e;
      wr(`DSTG_OFS_BURST, 32'h0000_00C8);
      wr(`DSTG_OFS_PITCH_A, 32'h0000_4000);
      wr(`DSTG_OFS_PITCH_B, 32'h0000_2000);
      play({4'h6, 4'h0, `DSTG_SEL_A, 2'b00}, 12);
      a = cap;
      for (int i = 0; i < 8; i++) check(a[i+4], a[i], "A period");
      play({4'h6, 4'h0, `DSTG_SEL_B, 2'b00}, 12);
      b = cap;
      for (int i = 0; i < 4; i++) check(b[i+8], b[i], "B period");
      play({4'h6, 4'h0, `DSTG_SEL_MIX, 2'b00}, 12);
      for (int i = 0; i < 12; i++) begin
         e = a[i] + b[i];
         check({cap[i]}, e[16:1], "mix");
      end
      wr(`DSTG_OFS_PITCH_A, 32'h0000_1000);
      play({4'h6, 4'h0, `DSTG_SEL_RAMP, 2'b00}, 8);
      for (int i = 0; i < 6; i++)
         check(cap[i+1] > cap[i], 1'b1, "ramp rises");
   endtask

   // Every keypad code in both rate families against a mix of pitch words computed from 2^16*f/rate
   task automatic t_keypad;
      int fr [8] = '{697, 770, 852, 941, 1209, 1336, 1477, 1633};
      logic [63:0] rt = 64'h3332_1022_2111_0003;
      logic [63:0] ct = 64'h2033_3321_0210_2101;
      logic signed [15:0] m [12];
      int dv;
      for (int f = 0; f < 2; f++) begin
         rate_family_11k <= f[0];
         dv = f ? 11025 : 12000;
         for (int k = 0; k < 16; k++) begin
            wr(`DSTG_OFS_PITCH_A, (65536 * fr[4 + ct[4*k +: 2]] + dv / 2) / dv);
            wr(`DSTG_OFS_PITCH_B, (65536 * fr[rt[4*k +: 2]] + dv / 2) / dv);
            play({4'h6, 4'h0, `DSTG_SEL_MIX, 2'b00}, 8);
            m = cap;
            play({4'h7, k[3:0], `DSTG_SEL_B, 2'b10}, 8);
            for (int i = 0; i < 8; i++)
               check(cap[i], m[i], "keypad");
         end
      end
   endtask

   task automatic close_out;
      if (mismatches == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset();
      t_pitch();
      t_burst();
      t_period();
      t_wave();
      t_keypad();
      close_out();
   end

   // Watchdog, well beyond the expected run
   initial begin
      repeat (90000) @(posedge ref_clk);
      mismatches++;
      close_out();
   end
endmodule // tb_top

`default_nettype wire
